// ### hdl/sdv_cfg.svh
// timing counts, code values and reference levels of the reference stepper
`ifndef SDV_CFG_SVH
`define SDV_CFG_SVH
`define SDV_CLK_NS 100
`define SDV_SAMPLE_NS 333
`define SDV_STEP_NS 3030
`define SDV_SAMPLE_CYC (`SDV_SAMPLE_NS / `SDV_CLK_NS)
`define SDV_STEP_CYC (`SDV_STEP_NS / `SDV_CLK_NS)
`define SDV_STABLE_READS 2'h3
`define SDV_CODE_RST 8'hFF
`define SDV_LEG_OFF_MIN 8'hFE
`define SDV_ALT5_OFF 5'h1F
`define SDV_LEG_TOP 9'h102
`define SDV_ALT_TOP 9'h0F8
`define SDV_ALT6_LOW_TOP 9'h07A
`define SDV_COARSE_STEP 9'h004
`define SDV_HALF_STEP 9'h002
`define SDV_FINE_STEP 9'h001
`endif

// ### hdl/sdv_pkg.sv
// types shared by the reference stepper files
package sdv_pkg;
	typedef enum logic [1:0] {
		SDV_LEG_A,
		SDV_LEG_B,
		SDV_ALT5,
		SDV_ALT6
	} sdv_mode_type;

	// level counts 6.25 mV units
	typedef struct packed {
		logic off;
		logic [8:0] level;
	} sdv_dac_type;

	typedef enum logic {
		SDV_HOLD,
		SDV_SLEW
	} sdv_state_type;
endpackage : sdv_pkg

// ### hdl/sdv_code_filter.sv
// code sampler and three-read validator
`timescale 1ns/10ps
`include "sdv_cfg.svh"
module sdv_code_filter #(
	parameter int WIDTH = 8,
	parameter int SAMPLE_CYC = `SDV_SAMPLE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] code_in,
	output logic [WIDTH-1:0] code_out,
	output logic valid_out
);
	logic [7:0] div_reg;
	logic [WIDTH-1:0] acc_reg;
	logic [WIDTH-1:0] cand_reg;
	logic [1:0] cnt_reg;
	logic init_reg;
	logic valid_reg;
	wire tick = (div_reg == 8'(SAMPLE_CYC - 1));
	wire differs = init_reg | (code_in != acc_reg);
	wire same_cand = (code_in == cand_reg) && (cnt_reg != 2'h0);
	wire [1:0] cnt_next = same_cand ? cnt_reg + 2'h1 : 2'h1;
	wire accept = tick && differs && (cnt_next == `SDV_STABLE_READS);

	assign code_out = acc_reg;
	assign valid_out = valid_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= tick ? 8'h00 : div_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= `SDV_CODE_RST;
			cand_reg <= `SDV_CODE_RST;
			cnt_reg <= 2'h0;
			init_reg <= 1'b1;
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= accept;
			if (tick) begin
				cand_reg <= code_in;
				cnt_reg <= (differs && !accept) ? cnt_next : 2'h0;
				if (accept) begin
					acc_reg <= code_in;
					init_reg <= 1'b0;
				end
			end
		end
	end

	a_valid_three_reads: assert property (@(posedge clk) disable iff (!rst_n)
		valid_reg |-> ($past(code_in, 1) == acc_reg) && ($past(code_in, 4) == acc_reg)
			&& ($past(code_in, 7) == acc_reg))
		else $error("code accepted without three matching reads");
	a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
		tick |=> !tick [*2])
		else $error("sampling tick too close");
	c_code_accepted: cover property (@(posedge clk) disable iff (!rst_n) valid_reg);
endmodule : sdv_code_filter

// ### hdl/sdv_ref_stepper.sv
// reference level control from processor voltage code
`timescale 1ns/10ps
`include "sdv_cfg.svh"
module sdv_ref_stepper
	import sdv_pkg::*;
#(
	parameter int STEP_CYC = `SDV_STEP_CYC
) (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic [7:0] VOLTAGE_CODE_INPUTS,
	input wire logic [1:0] CODE_MODE,
	output logic [8:0] DAC_TARGET_LEVEL,
	output logic OUTPUT_OFF,
	output logic SLEW_ACTIVE
);
	function automatic sdv_dac_type sdv_decode(input logic [7:0] c, input sdv_mode_type m);
		sdv_dac_type d;
		d.off = 1'b0;
		d.level = 9'h000;
		case (m)
			SDV_ALT5: begin
				if (c[4:0] == `SDV_ALT5_OFF) d.off = 1'b1;
				else d.level = `SDV_ALT_TOP - `SDV_COARSE_STEP * {4'h0, c[4:0]};
			end
			SDV_ALT6: begin
				if (!c[5]) d.level = `SDV_ALT_TOP - `SDV_COARSE_STEP * {4'h0, c[4:0]};
				else d.level = `SDV_ALT6_LOW_TOP - `SDV_HALF_STEP * {4'h0, c[4:0]};
			end
			default: begin
				if (c >= `SDV_LEG_OFF_MIN) d.off = 1'b1;
				else d.level = `SDV_LEG_TOP - {1'b0, c};
			end
		endcase
		return d;
	endfunction : sdv_decode

	logic [7:0] code;
	logic code_valid;
	sdv_dac_type dac_reg;
	sdv_dac_type dac_next;
	sdv_dac_type target_reg;
	sdv_dac_type target_next;
	sdv_state_type state_reg;
	sdv_state_type state_next;
	logic [7:0] step_div_reg;
	logic slew_reg;

	sdv_code_filter #(
		.WIDTH(8),
		.SAMPLE_CYC(`SDV_SAMPLE_CYC)
	) u_filter (
		.clk(MCLK),
		.rst_n(NRST),
		.code_in(VOLTAGE_CODE_INPUTS),
		.code_out(code),
		.valid_out(code_valid)
	);

	wire sdv_mode_type mode = sdv_mode_type'(CODE_MODE);
	wire alt_mode = (mode == SDV_ALT5) || (mode == SDV_ALT6);
	wire sdv_dac_type decoded = sdv_decode(code, mode);
	wire step_tick = (step_div_reg == 8'(STEP_CYC - 1));
	wire at_target = (dac_reg == target_reg);
	wire jump = dac_reg.off || target_reg.off;
	wire go_up = target_reg.level > dac_reg.level;

	assign target_next = code_valid ? decoded : target_reg;

	always_comb begin
		dac_next = dac_reg;
		state_next = state_reg;
		case (state_reg)
			SDV_HOLD: begin
				if (code_valid) begin
					if (!alt_mode) dac_next = decoded;
					else state_next = SDV_SLEW;
				end
			end
			SDV_SLEW: begin
				if (at_target && !code_valid) begin
					state_next = SDV_HOLD;
				end else if (step_tick && !at_target) begin
					if (jump) dac_next = target_reg;
					else if (go_up) dac_next.level = dac_reg.level + `SDV_FINE_STEP;
					else dac_next.level = dac_reg.level - `SDV_FINE_STEP;
				end
			end
			default: state_next = SDV_HOLD;
		endcase
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			step_div_reg <= 8'h00;
		end else begin
			step_div_reg <= step_tick ? 8'h00 : step_div_reg + 8'h01;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			dac_reg <= '{off: 1'b1, level: 9'h000};
			target_reg <= '{off: 1'b1, level: 9'h000};
			state_reg <= SDV_HOLD;
			slew_reg <= 1'b0;
		end else begin
			dac_reg <= dac_next;
			target_reg <= target_next;
			state_reg <= state_next;
			slew_reg <= (state_next == SDV_SLEW);
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			DAC_TARGET_LEVEL <= 9'h000;
			OUTPUT_OFF <= 1'b1;
			SLEW_ACTIVE <= 1'b0;
		end else begin
			DAC_TARGET_LEVEL <= dac_next.level;
			OUTPUT_OFF <= dac_next.off;
			SLEW_ACTIVE <= (state_next == SDV_SLEW);
		end
	end

	a_legacy_direct_load: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && !alt_mode && state_reg == SDV_HOLD)
			|=> ##1 ({OUTPUT_OFF, DAC_TARGET_LEVEL} == $past(decoded, 2)) && !SLEW_ACTIVE)
		else $error("legacy code not loaded directly");
	a_legacy_no_slew: assert property (@(posedge MCLK) disable iff (!NRST)
		(state_reg == SDV_HOLD && !alt_mode) |=> !SLEW_ACTIVE)
		else $error("legacy mode started a slew");
	a_slew_unit_step: assert property (@(posedge MCLK) disable iff (!NRST)
		(state_reg == SDV_SLEW && !jump && !$past(jump) && $past(state_reg) == SDV_SLEW)
			|-> (dac_reg.level - $past(dac_reg.level) <= 9'h001)
			|| ($past(dac_reg.level) - dac_reg.level <= 9'h001))
		else $error("slew moved more than one fine step");
	a_step_on_tick: assert property (@(posedge MCLK) disable iff (!NRST)
		($past(state_reg) == SDV_SLEW && dac_reg != $past(dac_reg)) |-> $past(step_tick))
		else $error("slew step off the stepping tick");
	a_step_spacing: assert property (@(posedge MCLK) disable iff (!NRST)
		step_tick |=> !step_tick [*8])
		else $error("stepping tick too close");
	a_slew_stops: assert property (@(posedge MCLK) disable iff (!NRST)
		(state_reg == SDV_SLEW && at_target && !code_valid) |=> state_reg == SDV_HOLD && !SLEW_ACTIVE)
		else $error("slew did not stop at target");
	a_hold_keeps_level: assert property (@(posedge MCLK) disable iff (!NRST)
		(state_reg == SDV_HOLD && !code_valid) |=> $stable(DAC_TARGET_LEVEL) && $stable(OUTPUT_OFF))
		else $error("reference moved while idle");
	a_mode_selects_slew: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && alt_mode && state_reg == SDV_HOLD) |=> state_reg == SDV_SLEW && SLEW_ACTIVE)
		else $error("alternate mode did not slew");
	a_alt_no_load: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && alt_mode && state_reg == SDV_HOLD) |=> $stable(dac_reg))
		else $error("alternate mode loaded reference directly");
	a_legacy_off_codes: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && !alt_mode && state_reg == SDV_HOLD && code >= `SDV_LEG_OFF_MIN)
			|=> ##1 OUTPUT_OFF)
		else $error("legacy off code did not turn output off");
	a_legacy_level: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && !alt_mode && state_reg == SDV_HOLD && code < `SDV_LEG_OFF_MIN)
			|=> !OUTPUT_OFF && (DAC_TARGET_LEVEL == `SDV_LEG_TOP - {1'b0, code}))
		else $error("legacy level off the fine step table");
	a_alt5_off_code: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && mode == SDV_ALT5 && code[4:0] == `SDV_ALT5_OFF) |=> target_reg.off)
		else $error("five-bit off code not decoded");
	a_alt5_top: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && mode == SDV_ALT5 && code[4:0] == 5'h00)
			|=> !target_reg.off && (target_reg.level == `SDV_ALT_TOP))
		else $error("five-bit top code not at top level");
	a_alt6_no_off: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && mode == SDV_ALT6) |=> !target_reg.off)
		else $error("six-bit code turned output off");
	a_alt6_half_range: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && mode == SDV_ALT6) |=> (target_reg.level <= `SDV_ALT6_LOW_TOP) == code[5])
		else $error("six-bit level in the wrong half of the table");
	a_retarget: assert property (@(posedge MCLK) disable iff (!NRST)
		(code_valid && state_reg == SDV_SLEW) |=> (target_reg == $past(decoded)) && state_reg == SDV_SLEW)
		else $error("running slew not retargeted");

	c_legacy_load: cover property (@(posedge MCLK) disable iff (!NRST)
		code_valid && !alt_mode);
	c_slew_done: cover property (@(posedge MCLK) disable iff (!NRST)
		state_reg == SDV_SLEW ##1 state_reg == SDV_HOLD);
	c_retarget: cover property (@(posedge MCLK) disable iff (!NRST)
		code_valid && state_reg == SDV_SLEW);
	c_off: cover property (@(posedge MCLK) disable iff (!NRST) $fell(OUTPUT_OFF));
endmodule : sdv_ref_stepper

// ### test/sdv_cpu_model.sv
// processor model that drives the voltage code
`timescale 1ns/10ps
module sdv_cpu_model #(
	parameter int HOLD_CYC = 15
) (
	input wire logic clk,
	output logic [7:0] code
);
	logic [7:0] want = 8'h12;

	// code lines move on the falling edge only
	always @(negedge clk) begin
		code <= want;
	end

	task automatic jump(input logic [7:0] val);
		@(posedge clk) want = val;
	endtask : jump

	task automatic walk(input logic [7:0] val);
		while (want != val) begin
			@(posedge clk) want = (want < val) ? want + 8'h01 : want - 8'h01;
			repeat (HOLD_CYC) @(negedge clk);
		end
	endtask : walk

	// short pulse, shorter than three reads
	task automatic glitch(input logic [7:0] val);
		logic [7:0] keep;
		keep = want;
		@(posedge clk) want = val;
		@(posedge clk) want = keep;
	endtask : glitch
endmodule : sdv_cpu_model

// ### test/dynamic_vid_reference_stepper_test.sv
// self-checking bench of the reference stepper
`timescale 1ns/10ps
module dynamic_vid_reference_stepper_test;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] mode;
	logic [7:0] code;
	logic [8:0] level;
	logic [8:0] lo;
	logic off;
	logic slew;
	int bad_count = 0;
	int cmp_count = 0;

	initial begin
		forever #50 mclk = ~mclk;
	end

	sdv_cpu_model cpu_u (.clk(mclk), .code(code));
	sdv_ref_stepper dut_u (.MCLK(mclk), .NRST(nrst), .VOLTAGE_CODE_INPUTS(code),
		.CODE_MODE(mode), .DAC_TARGET_LEVEL(level), .OUTPUT_OFF(off), .SLEW_ACTIVE(slew));

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] want);
		cmp_count++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick

	// mode pins, changed only at a falling edge or at start
	task automatic set_mode(input logic [1:0] m);
		mode = m;
	endtask : set_mode

	// waits out a transition, keeping the lowest level seen
	task automatic settle();
		tick(45);
		lo = level;
		for (int i = 0; i < 6000 && slew !== 1'b0; i++) begin
			@(negedge mclk);
			if (level < lo) lo = level;
		end
		tick(2);
		check("slew", 9'(slew), 9'h000);
	endtask : settle

	task automatic t_legacy();
		tick(15);
		check("level", level, 9'h102 - 9'h012);
		cpu_u.walk(8'h10);
		check("level", level, 9'h102 - 9'h010);
		check("slew", 9'(slew), 9'h000);
		cpu_u.glitch(8'h11);
		tick(15);
		check("level", level, 9'h102 - 9'h010);
		set_mode(sdv_pkg::SDV_LEG_B);
		cpu_u.walk(8'hFE);
		check("off", 9'(off), 9'h001);
		check("level", level, 9'h000);
	endtask : t_legacy

	task automatic t_alt5();
		set_mode(sdv_pkg::SDV_ALT5);
		cpu_u.jump(8'h00);
		settle();
		check("level", level, 9'h0F8);
		check("off", 9'(off), 9'h000);
		cpu_u.jump(8'h04);
		tick(12);
		check("slew", 9'(slew), 9'h001);
		tick(440);
		check("mid", 9'(level > 9'h0E8 && level < 9'h0F8), 9'h001);
		settle();
		check("level", level, 9'h0F8 - 9'h010);
		cpu_u.jump(8'h1F);
		settle();
		check("off", 9'(off), 9'h001);
	endtask : t_alt5

	task automatic t_alt6();
		set_mode(sdv_pkg::SDV_ALT6);
		cpu_u.jump(8'h00);
		settle();
		check("level", level, 9'h0F8);
		cpu_u.jump(8'h21);
		tick(300);
		cpu_u.jump(8'h1E);
		settle();
		check("level", level, 9'h0F8 - 9'h078);
		check("lowest", lo, 9'h080);
		cpu_u.jump(8'h3F);
		settle();
		check("level", level, 9'h07A - 9'h03E);
	endtask : t_alt6

	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		set_mode(sdv_pkg::SDV_LEG_A);
		tick(3);
		check("level", level, 9'h000);
		check("off", 9'(off), 9'h001);
		check("slew", 9'(slew), 9'h000);
		nrst = 1'b1;
		t_legacy();
		t_alt5();
		t_alt6();
		finish_test();
	end

	initial begin
		#3000000;
		bad_count++;
		finish_test();
	end
endmodule : dynamic_vid_reference_stepper_test
